// ===== design/cpu_monitor_params.svh
// Bit positions, select codes and reset values for the CPU monitor block.
`ifndef CPU_MONITOR_PARAMS_SVH
`define CPU_MONITOR_PARAMS_SVH
// Channel bit n (bit 0 leftmost) sits at vector index 15-n.
`define CTL_CHK_READ 15
`define CTL_CHK_WRITE 14
`define CTL_CHK_CPU 13
`define CTL_CHK_CHAN 12
`define CTL_STOP_BOUNDS 11
`define CTL_BOUNDS_EN 10
`define CTL_COUNT_A 9
`define CTL_COUNT_B 8
`define CTL_OVF_ONLY 7
`define CTL_STOP_A 6
`define CTL_STOP_B 5
`define CTL_CARRY_A1 4
`define CTL_SPEC_B 0
`define EVS_CODE1_HI 15
`define EVS_CODE1_LO 11
`define EVS_CODE2_HI 10
`define EVS_CODE2_LO 6
`define EVS_ALL_JOBS 4
`define EVS_MON 3
`define EVS_JOB 2
`define EVS_DF56 1
`define EVS_DF57 0
`define CMD_RUN 12
`define CMD_CLR_FAULT 8
`define CMD_READ 7
`define EV_FUNC_MATCH 5'h12
`define SPEC_RESET 16'h0000
`define SWORD_SHIFT 7
`endif

// ===== design/cpu_monitor_pkg.sv
// Types shared by the CPU monitor block.
package cpu_monitor_pkg;
    typedef enum logic [3:0] {
        SEL_IADDR = 4'h0,
        SEL_DFLAGS = 4'h1,
        SEL_PKG_ADDR = 4'h2,
        SEL_INTS_CHAN = 4'h3,
        SEL_PARITY = 4'h4,
        SEL_BOUNDS = 4'h5,
        SEL_COUNTERS = 4'h6
    } disp_sel_e;
    typedef enum logic [0:0] {
        ST_RUN = 1'b0,
        ST_HALT = 1'b1
    } run_state_e;
endpackage

// ===== design/cpu_monitor_counter_control.sv
// CPU-side monitor: bounds stop, event counters and display registers.
// What this block does
// - After a bounds stop, clear-fault must precede the next bounds hit report.
// - With fault cleared, the run bit restarts the CPU at the next instruction.
// - Bounds enable activates whichever check categories are set.
// - Count bits start pair A and pair B; setup must precede them.
// - Read clears counters fully, or in overflow mode only the top bits of counters that are not a low half.
// - Stop bit of a pair halts the CPU on its event; clear-fault clears it.
// - Carry bits B..E enable carries into A1, A2, B1, B2.
// - No carries gives two 16-bit counters; one carry forms 32 bits.
// - Spec bit routes event-select word to pair B or pair A.
// - Event code fields pick events for first and second counters.
// - All-jobs mask lets any job count.
// - Monitor-mode mask counts while the CPU is in monitor mode.
// - Job-mode mask counts during jobs selected for monitoring.
// - Data-flag masks count while the matching data flag is set.
// - Function code matches select code on mask bits; zero mask counts all.
// - Display gets instruction address plus a register chosen by 4-bit code.
// - Instruction address and selected data return on separate outputs.
// - Codes 0-3 return address, flags, package addresses, interrupts.
// - Code 4 returns parity flags, float counts, first parity address.
// - Code 5 returns first bounds-hit address, sword-checked, held.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_monitor_params.svh"
module cpu_monitor_counter_control (
    // Clock, reset, enable
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Station output channels (asynchronous pins)
    input wire logic [15:0] counter_control_channel_i,
    input wire logic [15:0] event_select_channel_i,
    input wire logic [15:0] function_match_channel_i,
    input wire logic [15:0] maintenance_command_channel_i,
    input wire logic [15:0] bounds_address_channel_i,
    input wire logic bounds_upper_sel_i,
    // CPU status on the same clock
    input wire logic [31:0] event_first_i,
    input wire logic [31:0] event_second_i,
    input wire logic instr_issue_i,
    input wire logic [7:0] instr_func_i,
    input wire logic monitor_mode_i,
    input wire logic job_mode_i,
    input wire logic job_monitor_en_i,
    input wire logic [63:0] data_flags_i,
    input wire logic mem_ref_i,
    input wire logic [3:0] mem_ref_class_i,
    input wire logic [31:0] mem_ref_addr_i,
    input wire logic [7:0] parity_fault_i,
    input wire logic [31:0] parity_addr_i,
    input wire logic [5:0] fp_count_i,
    input wire logic [63:0] current_instruction_pointer_i,
    input wire logic [31:0] pkg_addr_i,
    input wire logic [31:0] page_zero_addr_i,
    input wire logic [14:0] ext_int_i,
    input wire logic [23:0] chan_active_i,
    // Fault status and halt
    output logic cpu_halt_o,
    output logic fault_bounds_o,
    output logic fault_event_stop_o,
    // Display registers
    output logic [63:0] display_addr_o,
    output logic [63:0] display_data_o,
    output logic display_valid_o
);
    import cpu_monitor_pkg::*;

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    localparam int SW = 81;
    logic [SW-1:0] sy1_q, sy2_q;
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            sy1_q <= '0;
            sy2_q <= '0;
        end else if (ce_i) begin
            sy1_q <= {counter_control_channel_i, event_select_channel_i,
                      function_match_channel_i,
                      maintenance_command_channel_i,
                      bounds_address_channel_i, bounds_upper_sel_i};
            sy2_q <= sy1_q;
        end
    end
    wire [15:0] ctl = sy2_q[80:65];
    wire [15:0] evs = sy2_q[64:49];
    wire [15:0] fmc = sy2_q[48:33];
    wire [15:0] cmd = sy2_q[32:17];
    wire [15:0] bnd = sy2_q[16:1];
    wire bnd_up = sy2_q[0];

    // ------------------------------------------------------------
    // Command edges and channel latches
    // ------------------------------------------------------------
    logic [2:0] cmd_prev_q;
    logic [15:0] spec_q [2];
    logic [15:0] lo_q, hi_q;
    wire [2:0] cmd_now = {cmd[`CMD_RUN], cmd[`CMD_CLR_FAULT], cmd[`CMD_READ]};
    wire [2:0] cmd_rise = cmd_now & ~cmd_prev_q;
    wire run_p = cmd_rise[2];
    wire clrf_p = cmd_rise[1];
    wire read_p = cmd_rise[0];
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            cmd_prev_q <= '0;
            spec_q[0] <= `SPEC_RESET;
            spec_q[1] <= `SPEC_RESET;
            lo_q <= '0;
            hi_q <= '0;
        end else if (ce_i) begin
            cmd_prev_q <= cmd_now;
            spec_q[ctl[`CTL_SPEC_B]] <= evs;
            if (bnd_up) hi_q <= bnd;
            else lo_q <= bnd;
        end
    end

    // ------------------------------------------------------------
    // Bounds check
    // ------------------------------------------------------------
    // Only the sword part of the address is compared.
    wire [15:0] ref_sw = mem_ref_addr_i[`SWORD_SHIFT+15:`SWORD_SHIFT];
    wire cat_hit = |(mem_ref_class_i & ctl[15:12]);
    wire in_bnd = (ref_sw >= lo_q) && (ref_sw <= hi_q);
    wire bnd_hit = mem_ref_i && ctl[`CTL_BOUNDS_EN] && cat_hit && in_bnd;
    logic bnd_flag_q;
    logic [31:0] bnd_addr_q;
    wire bnd_new = bnd_hit && !bnd_flag_q;
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            bnd_flag_q <= 1'b0;
            bnd_addr_q <= '0;
        end else if (ce_i) begin
            if (bnd_new) begin
                bnd_flag_q <= 1'b1;
                bnd_addr_q <= mem_ref_addr_i;
            end else if (clrf_p) begin
                bnd_flag_q <= 1'b0;
                bnd_addr_q <= '0;
            end
        end
    end

    // ------------------------------------------------------------
    // Parity capture
    // ------------------------------------------------------------
    logic [7:0] par_flags_q;
    logic par_seen_q;
    logic [31:0] par_addr_q;
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            par_flags_q <= '0;
            par_seen_q <= 1'b0;
            par_addr_q <= '0;
        end else if (ce_i) begin
            par_flags_q <= (clrf_p ? 8'h00 : par_flags_q) | parity_fault_i;
            if (|parity_fault_i && !par_seen_q) begin
                par_seen_q <= 1'b1;
                par_addr_q <= parity_addr_i;
            end else if (clrf_p) begin
                par_seen_q <= 1'b0;
                par_addr_q <= '0;
            end
        end
    end

    // ------------------------------------------------------------
    // Counters A1, A2, B1, B2
    // ------------------------------------------------------------
    // Every gate input is an argument, so a change of mode alone
    // re-evaluates the gate in the continuous assignment below.
    function automatic logic gate_ok(input logic [15:0] s, input logic mon,
                                     input logic job, input logic jen,
                                     input logic df56, input logic df57);
        logic job_ok;
        job_ok = job && s[`EVS_JOB] && (s[`EVS_ALL_JOBS] || jen);
        gate_ok = (df56 && s[`EVS_DF56]) || (df57 && s[`EVS_DF57]) ||
                  (mon && s[`EVS_MON]) || job_ok;
    endfunction

    logic [15:0] cnt_q [4];
    wire [3:0] ev;
    wire [3:0] inc;
    wire [3:0] carry_en;
    wire [1:0] pair_on = {ctl[`CTL_COUNT_B], ctl[`CTL_COUNT_A]};
    wire [1:0] stop_en = {ctl[`CTL_STOP_B], ctl[`CTL_STOP_A]};
    wire func_hit = instr_issue_i &&
        (((fmc[15:8] ^ instr_func_i) & fmc[7:0]) == 8'h00);
    wire ovf_only = ctl[`CTL_OVF_ONLY];

    genvar k;
    generate
        for (k = 0; k < 4; k++) begin : g_cnt
            localparam int P = k / 2;
            wire [4:0] code = (k % 2 == 0) ?
                spec_q[P][`EVS_CODE1_HI:`EVS_CODE1_LO] :
                spec_q[P][`EVS_CODE2_HI:`EVS_CODE2_LO];
            wire raw = (k % 2 == 0) ?
                ((code == `EV_FUNC_MATCH) ? func_hit : event_first_i[code]) :
                event_second_i[code];
            assign ev[k] = raw && pair_on[P] &&
                gate_ok(spec_q[P], monitor_mode_i, job_mode_i,
                        job_monitor_en_i, data_flags_i[56], data_flags_i[57]);
            assign carry_en[k] = ctl[`CTL_CARRY_A1-k];
            // Carry only follows the partner's own event, so two set
            // carry bits cannot form a combinational loop.
            assign inc[k] = ev[k] || (carry_en[k] && ev[k^1] &&
                            cnt_q[k^1] == 16'hFFFF);
            // A counter that carries into its partner is a low half.
            wire keep_top = carry_en[k^1];
            always_ff @(posedge mclk_i) begin
                if (!rst_n_i) begin
                    cnt_q[k] <= '0;
                end else if (ce_i) begin
                    if (read_p && !ovf_only) begin
                        cnt_q[k] <= '0;
                    end else if (read_p && !keep_top) begin
                        cnt_q[k] <= {1'b0, cnt_q[k][14:0]};
                    end else if (inc[k]) begin
                        cnt_q[k] <= cnt_q[k] + 16'h0001;
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Halt control
    // ------------------------------------------------------------
    wire stop_ev = (stop_en[0] && |ev[1:0]) || (stop_en[1] && |ev[3:2]);
    logic evstop_q;
    run_state_e st_q;
    wire bnd_stop = bnd_new && ctl[`CTL_STOP_BOUNDS];
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            evstop_q <= 1'b0;
            st_q <= ST_RUN;
        end else if (ce_i) begin
            if (stop_ev) evstop_q <= 1'b1;
            else if (clrf_p) evstop_q <= 1'b0;
            case (st_q)
                ST_RUN: if (stop_ev || bnd_stop) st_q <= ST_HALT;
                ST_HALT: if (run_p && !bnd_flag_q && !evstop_q)
                    st_q <= ST_RUN;
                default: st_q <= ST_RUN;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Display registers
    // ------------------------------------------------------------
    disp_sel_e sel;
    assign sel = disp_sel_e'(cmd[3:0]);
    wire [63:0] sel_data =
        (sel == SEL_IADDR) ? current_instruction_pointer_i :
        (sel == SEL_DFLAGS) ? data_flags_i :
        (sel == SEL_PKG_ADDR) ? {pkg_addr_i, page_zero_addr_i} :
        (sel == SEL_INTS_CHAN) ? {17'h00000, ext_int_i, chan_active_i,
                                  8'h00} :
        (sel == SEL_PARITY) ? {par_flags_q, 18'h00000, fp_count_i,
                               par_addr_q} :
        (sel == SEL_BOUNDS) ? {bnd_addr_q, 32'h00000000} :
        (sel == SEL_COUNTERS) ? {cnt_q[0], cnt_q[1], cnt_q[2], cnt_q[3]} :
        64'h0000000000000000;
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            display_addr_o <= '0;
            display_data_o <= '0;
            display_valid_o <= 1'b0;
            cpu_halt_o <= 1'b0;
            fault_bounds_o <= 1'b0;
            fault_event_stop_o <= 1'b0;
        end else if (ce_i) begin
            display_valid_o <= read_p;
            if (read_p) begin
                display_addr_o <= current_instruction_pointer_i;
                display_data_o <= sel_data;
            end
            cpu_halt_o <= (st_q == ST_HALT);
            fault_bounds_o <= bnd_flag_q;
            fault_event_stop_o <= evstop_q;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    bounds_hit_held_a: assert property (ce_i && bnd_flag_q && !clrf_p |=>
        bnd_flag_q && $stable(bnd_addr_q))
        else $error("bounds flag or address changed without clear");
    restart_gate_a: assert property (ce_i && st_q == ST_HALT &&
        (bnd_flag_q || evstop_q) |=> st_q == ST_HALT)
        else $error("halt left while a fault is pending");
    bounds_enable_a: assert property (!ctl[`CTL_BOUNDS_EN] |-> !bnd_hit)
        else $error("bounds hit while checking disabled");
    count_gate_a: assert property (!pair_on[0] |-> ev[1:0] == 2'b00)
        else $error("pair A counted without count bit");
    full_clear_a: assert property (ce_i && read_p && !ovf_only |=>
        cnt_q[0] == 16'h0000 && cnt_q[3] == 16'h0000)
        else $error("counters not cleared after read");
    stop_halt_a: assert property (ce_i && stop_ev |=> ##1
        cpu_halt_o && fault_event_stop_o)
        else $error("stop event did not halt");
    carry_a2_a: assert property (ce_i && !read_p && carry_en[1] &&
        ev[0] && !ev[1] && cnt_q[0] == 16'hFFFF |=>
        cnt_q[1] == $past(cnt_q[1]) + 16'h0001)
        else $error("carry into second counter missing");
    no_carry_a: assert property (ce_i && !read_p && carry_en[1] == 1'b0 &&
        !ev[1] |=> $stable(cnt_q[1]))
        else $error("independent counter moved");
    func_match_a: assert property (fmc[7:0] == 8'h00 && instr_issue_i
        |-> func_hit)
        else $error("zero mask did not match");
    display_load_a: assert property (ce_i && read_p |=> display_valid_o &&
        display_addr_o == $past(current_instruction_pointer_i))
        else $error("display address not loaded");
    read_pulse_a: assert property (ce_i && display_valid_o |=>
        !display_valid_o)
        else $error("display valid longer than one cycle");

    bounds_stop_c: cover property (bnd_stop ##[1:20] run_p);
    event_stop_c: cover property (stop_ev ##[1:40] clrf_p);
    chain_c: cover property (carry_en[1] && ev[0] && cnt_q[0] == 16'hFFFF);
    read_c: cover property (read_p && sel == SEL_COUNTERS);
endmodule // cpu_monitor_counter_control
`default_nettype wire

// ===== testbench/station_model.sv
// Maintenance station model that drives the CPU monitor channels.
`timescale 1ns/1ps
`default_nettype none
module station_model (
    // Clock
    input wire logic mclk_i,
    // Output channels
    output var logic [15:0] ctl_o,
    output var logic [15:0] evs_o,
    output var logic [15:0] fm_o,
    output var logic [15:0] cmd_o,
    output var logic [15:0] bnd_o,
    output var logic upper_o
);
    initial begin
        ctl_o = 16'h0000;
        evs_o = 16'h0000;
        fm_o = 16'h0000;
        cmd_o = 16'h0000;
        bnd_o = 16'h0000;
        upper_o = 1'b0;
    end
    // Each word is held across the synchronisers before the next change,
    // so setup words always land before the bits that act on them.
    task automatic put(input int ch, input logic [15:0] v, input int n);
        @(posedge mclk_i);
        case (ch)
            0: ctl_o <= v;
            1: evs_o <= v;
            2: fm_o <= v;
            3: cmd_o <= v;
            4: bnd_o <= v;
            default: upper_o <= v[0];
        endcase
        repeat (n) @(posedge mclk_i);
    endtask
endmodule // station_model
`default_nettype wire

// ===== testbench/cpu_monitor_counter_control_tb_top.sv
// Self-checking testbench for the CPU monitor counter control block.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_monitor_params.svh"
module cpu_monitor_counter_control_tb_top;
    import cpu_monitor_pkg::*;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ce = 1'b1;
    logic [15:0] ctl, evs, fm, cmd, bnd;
    logic upper, halt, fbnd, fstop, dvalid;
    logic [63:0] daddr, ddata;
    logic [31:0] ev1 = 32'h0, ev2 = 32'h0, maddr = 32'h0;
    logic issue = 1'b0, mon = 1'b1, job = 1'b0, jen = 1'b0, mref = 1'b0;
    logic [7:0] func = 8'h00, pflt = 8'h00;
    logic [3:0] mclass = 4'h8;
    logic [63:0] ip = 64'h0123_4567_89AB_CDEF;
    logic [63:0] flags = 64'hFEDC_BA98_7654_3210;
    logic [31:0] pkg = 32'h1111_2222, pz = 32'h3333_4444;
    logic [31:0] paddr = 32'hCAFE_0000;
    logic [5:0] fp = 6'h2A;
    logic [14:0] ext = 15'h4001;
    logic [23:0] chan = 24'h80_0001;
    int err_count = 0;
    int checks = 0;
    int i;
    always #20 mclk_i = ~mclk_i;
    station_model station_model_i (.mclk_i(mclk_i), .ctl_o(ctl),
        .evs_o(evs), .fm_o(fm), .cmd_o(cmd), .bnd_o(bnd), .upper_o(upper));
    cpu_monitor_counter_control cpu_monitor_counter_control_i (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce),
        .counter_control_channel_i(ctl), .event_select_channel_i(evs),
        .function_match_channel_i(fm), .maintenance_command_channel_i(cmd),
        .bounds_address_channel_i(bnd), .bounds_upper_sel_i(upper),
        .event_first_i(ev1), .event_second_i(ev2), .instr_issue_i(issue),
        .instr_func_i(func), .monitor_mode_i(mon), .job_mode_i(job),
        .job_monitor_en_i(jen), .data_flags_i(flags), .mem_ref_i(mref),
        .mem_ref_class_i(mclass), .mem_ref_addr_i(maddr),
        .parity_fault_i(pflt), .parity_addr_i(paddr), .fp_count_i(fp),
        .current_instruction_pointer_i(ip), .pkg_addr_i(pkg),
        .page_zero_addr_i(pz), .ext_int_i(ext), .chan_active_i(chan),
        .cpu_halt_o(halt), .fault_bounds_o(fbnd),
        .fault_event_stop_o(fstop), .display_addr_o(daddr),
        .display_data_o(ddata), .display_valid_o(dvalid));
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk64(input string nm, input logic [63:0] e, g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, g);
        chk64(nm, {63'h0, e}, {63'h0, g});
    endtask
    task automatic results;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    function automatic logic [15:0] bm(input int b);
        return 16'h0001 << b;
    endfunction
    task automatic put(input int ch, input logic [15:0] v, input int n = 4);
        station_model_i.put(ch, v, n);
    endtask
    task automatic pulse(input int b);
        put(3, bm(b));
        put(3, 16'h0000);
        @(negedge mclk_i);
    endtask
    task automatic rd(input logic [3:0] sel, input logic [63:0] e);
        int k;
        put(3, {12'h000, sel});
        put(3, {12'h000, sel} | bm(`CMD_READ), 0);
        for (k = 0; k < 12 && dvalid !== 1'b1; k++) @(negedge mclk_i);
        chk1("display_valid", 1'b1, dvalid);
        chk64("display_addr", ip, daddr);
        chk64("display_data", e, ddata);
        put(3, {12'h000, sel});
    endtask
    // The counting spec is loaded with the count bits low, then enabled.
    task automatic arm(input logic [15:0] spec, input logic [4:0] c1, c2,
                       input logic [15:0] g, c);
        put(0, spec);
        put(1, (16'(c1) << `EVS_CODE1_LO) | (16'(c2) << `EVS_CODE2_LO) | g);
        put(0, spec | c);
    endtask
    task automatic evp(input int code, input int n, input bit second);
        repeat (n) begin
            @(posedge mclk_i);
            if (second) ev2 <= 32'h1 << code;
            else ev1 <= 32'h1 << code;
            @(posedge mclk_i);
            ev1 <= 32'h0;
            ev2 <= 32'h0;
        end
        repeat (4) @(posedge mclk_i);
        @(negedge mclk_i);
    endtask
    task automatic mem(input logic [31:0] a, input logic [3:0] cls);
        @(posedge mclk_i);
        mref <= 1'b1;
        maddr <= a;
        mclass <= cls;
        @(posedge mclk_i);
        mref <= 1'b0;
        repeat (4) @(posedge mclk_i);
        @(negedge mclk_i);
    endtask
    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    logic [3:0] codes [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h7};
    int gb [8] = '{`EVS_MON, `EVS_MON, `EVS_JOB, `EVS_JOB, `EVS_JOB,
                   `EVS_DF56, `EVS_DF56, `EVS_DF57};
    logic [4:0] lv [8] = '{5'h08, 5'h00, 5'h14, 5'h04, 5'h06, 5'h01, 5'h00,
                           5'h01};
    logic [7:0] gx = 8'hB5;
    logic [15:0] fmw [3] = '{16'hA5F0, 16'hA5F0, 16'hA500};
    logic [7:0] fnc [3] = '{8'hA3, 8'h55, 8'h55};
    logic [2:0] fx = 3'h5;
    logic [63:0] ex [5];
    initial begin
        repeat (80000) @(posedge mclk_i);
        err_count++;
        results();
    end
    initial begin
        ex = '{ip, flags, {pkg, pz}, {17'h0, ext, chan, 8'h00}, 64'h0};
        repeat (20) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(negedge mclk_i);
        chk1("halt", 1'b0, halt);
        chk1("display_valid", 1'b0, dvalid);
        for (i = 0; i < 5; i++) rd(codes[i], ex[i]);
        arm(16'h0000, 5'h01, 5'h03, bm(`EVS_MON), bm(`CTL_COUNT_A));
        evp(1, 5, 0);
        // Events while the enable is low must leave the counts alone.
        @(posedge mclk_i);
        ce <= 1'b0;
        evp(1, 2, 0);
        @(posedge mclk_i);
        ce <= 1'b1;
        evp(3, 2, 1);
        rd(SEL_COUNTERS, {16'h0005, 16'h0002, 32'h0});
        rd(SEL_COUNTERS, 64'h0);
        for (i = 0; i < 8; i++) begin
            {mon, job, jen} <= lv[i][3:1];
            flags <= lv[i][0] ? 64'h0300_0000_0000_0080 : 64'h0;
            arm(16'h0000, 5'h01, 5'h00, bm(gb[i]) |
                (lv[i][4] ? bm(`EVS_ALL_JOBS) : 16'h0000), bm(`CTL_COUNT_A));
            evp(1, 1, 0);
            rd(SEL_COUNTERS, {15'h0, gx[i], 48'h0});
        end
        mon <= 1'b1;
        arm(bm(`CTL_SPEC_B), 5'h02, 5'h00, bm(`EVS_MON), bm(`CTL_COUNT_B));
        evp(2, 3, 0);
        rd(SEL_COUNTERS, {32'h0, 16'h0003, 16'h0000});
        for (i = 0; i < 3; i++) begin
            put(2, fmw[i]);
            arm(16'h0000, `EV_FUNC_MATCH, 5'h00, bm(`EVS_MON),
                bm(`CTL_COUNT_A));
            @(posedge mclk_i);
            issue <= 1'b1;
            func <= fnc[i];
            @(posedge mclk_i);
            issue <= 1'b0;
            repeat (3) @(posedge mclk_i);
            rd(SEL_COUNTERS, {15'h0, fx[i], 48'h0});
        end
        // Pair A chained to 32 bits with A1 low, pair B as two 16-bit
        // counters; one long run wraps A1 and sets the top bit of B2.
        arm(bm(`CTL_SPEC_B), 5'h01, 5'h03, bm(`EVS_MON),
            bm(`CTL_COUNT_B));
        arm(bm(`CTL_CARRY_A1 - 1) | bm(`CTL_COUNT_B), 5'h01, 5'h00,
            bm(`EVS_MON), bm(`CTL_COUNT_A));
        @(posedge mclk_i);
        ev1 <= 32'h2;
        ev2 <= 32'h8;
        repeat (32769) @(posedge mclk_i);
        ev2 <= 32'h0;
        repeat (32769) @(posedge mclk_i);
        ev1 <= 32'h0;
        put(0, bm(`CTL_CARRY_A1 - 1) | bm(`CTL_OVF_ONLY) |
            bm(`CTL_COUNT_A) | bm(`CTL_COUNT_B));
        rd(SEL_COUNTERS, 64'h0002_0001_0002_8001);
        rd(SEL_COUNTERS, 64'h0002_0001_0002_0001);
        arm(16'h0000, 5'h01, 5'h00, bm(`EVS_MON),
            bm(`CTL_COUNT_A) | bm(`CTL_STOP_A));
        evp(1, 1, 0);
        chk1("event_stop", 1'b1, fstop);
        chk1("halt", 1'b1, halt);
        put(0, 16'h0000);
        pulse(`CMD_RUN);
        chk1("halt", 1'b1, halt);
        pulse(`CMD_CLR_FAULT);
        chk1("event_stop", 1'b0, fstop);
        pulse(`CMD_RUN);
        chk1("halt", 1'b0, halt);
        put(5, 16'h0000);
        put(4, 16'h0010);
        put(5, 16'h0001);
        put(4, 16'h0011);
        put(0, bm(`CTL_CHK_READ) | bm(`CTL_STOP_BOUNDS));
        mem(32'h0000_0880, 4'h8);
        chk1("bounds_fault", 1'b0, fbnd);
        put(0, bm(`CTL_CHK_READ) | bm(`CTL_STOP_BOUNDS) | bm(`CTL_BOUNDS_EN));
        mem(32'h0000_0880, 4'h4);
        chk1("bounds_fault", 1'b0, fbnd);
        mem(32'h0000_0880, 4'h8);
        chk1("bounds_fault", 1'b1, fbnd);
        chk1("halt", 1'b1, halt);
        mem(32'h0000_0800, 4'h8);
        @(posedge mclk_i);
        pflt <= 8'h81;
        @(posedge mclk_i);
        pflt <= 8'h00;
        rd(SEL_BOUNDS, {32'h0000_0880, 32'h0});
        rd(SEL_PARITY, {8'h81, 18'h0, fp, paddr});
        pulse(`CMD_CLR_FAULT);
        chk1("bounds_fault", 1'b0, fbnd);
        rd(SEL_BOUNDS, 64'h0);
        rd(SEL_PARITY, {26'h0, fp, 32'h0});
        pulse(`CMD_RUN);
        chk1("halt", 1'b0, halt);
        results();
    end
endmodule // cpu_monitor_counter_control_tb_top
`default_nettype wire
